// file: src/rfw_engine.sv
// Purpose: ramp, FSK/PSK and slip-reduction control of a fractional-N divider
// Assumes: ref_clk is the phase-detector clock; config ports static while ramping
// Notes: analog charge pump and serial framing live outside
`timescale 1ns/1ns
`include "rfw_cfg.svh"

// Behaviour
// R1: FSK adds or subtracts deviation word shifted by deviation shift.
// R2: Programmed divide value is FSK centre; modulation pin picks direction.
// R3: PSK mode sets output phase 0 or 180 from modulation pin.
// R4: Each ramp step changes divide value by deviation word times two^shift.
// R5: Step interval is clk1 times clk2 phase-detector periods.
// R6: Twenty-bit step count sets steps before direction or state changes.
// R7: Controller keeps integer growth within 256 during a ramp; neither host nor engine checks it, and RFW_INT_SPAN is unused.
// R8: Every ramp starts from programmed integer and fractional value.
// R9: Single ramp burst climbs step count steps then holds final value.
// R10: Single sawtooth burst restores initial value at next interval then holds.
// R11: Sawtooth ramp repeats the sawtooth burst until ramp disabled.
// R12: Triangular ramp climbs, descends same count, repeats until disabled.
// R13: Controller selects ramp type then sets ramp start.
// R14: Controller writes settings in documented order, divide value last.
// R15: Imminent slip enables one extra constant cell, polarity follows tuning need.
// R16: Each further imminent slip adds a cell, at most seven.
// R17: Past target, extra cells turn off one at a time to none.
// R18: Slip reduction acts only while its enable is set.
// R19: Controller enables slip reduction only with positive detector polarity.
// R20: Ramp type encodes triangular as 01 and single ramp burst as 11.
// R21: Ramp clock select picks internal timer or modulation pin edges.
// R22: Timer reloads to clk1 times clk2 and strobes once per expiry.
module rfw_engine
    import rfw_pkg::*;
(
    input wire logic ref_clk,                       // Phase-detector clock
    input wire logic reset,                         // Sync reset, active high
    input wire rfw_pkg::rfw_n_t n_prog,             // Programmed divide value
    input wire rfw_pkg::rfw_ramp_cfg_t cfg,         // Ramp settings
    input wire logic ramp_start,                    // Ramp enable level
    input wire logic fsk_en,                        // FSK mode
    input wire logic psk_en,                        // PSK mode
    input wire logic mod_pin,                       // Modulation pin, asynchronous
    input wire logic slip_reduction_en,             // Slip reduction enable
    input wire logic slip_imminent,                 // Pulse: slip about to occur
    input wire logic slip_up,                       // Tuning voltage must rise
    input wire logic target_passed,                 // VCO went past target
    output logic [`RFW_INT_W+`RFW_FRAC_W-1:0] n_out, // Divide value in use
    output logic phase_flip,                        // 180 degree phase
    output logic [`RFW_CELL_W-1:0] extra_cells,     // Extra cells on
    output logic cell_source,                       // 1 sources, 0 sinks
    output logic ramp_busy,                         // Ramp running
    output logic step_strobe                        // One-cycle step advance
);
    import rfw_pkg::*;
    localparam int NW = `RFW_INT_W + `RFW_FRAC_W;
    localparam int TW = 2 * `RFW_DIV_W;

    // ****************************************
    // Modulation pin synchroniser
    // ****************************************
    logic [2:0] mod_sync;
    logic mod_level;
    logic mod_prev;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mod_sync <= 3'h0;
            mod_level <= 1'b0;
        end else begin
            mod_sync <= {mod_sync[1:0], mod_pin};
            if (mod_sync[1] == mod_sync[2]) begin
                mod_level <= mod_sync[2];
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mod_prev <= 1'b0;
        end else begin
            mod_prev <= mod_level;
        end
    end
    wire mod_rise = mod_level & ~mod_prev;

    // ****************************************
    // Interval timer
    // ****************************************
    logic [TW-1:0] timer;
    logic [TW-1:0] reload;
    assign reload = TW'(cfg.clk1_div) * TW'(cfg.clk2_div); // R5
    wire tick_int = ramp_busy && (timer <= TW'(1)); // R22
    always_ff @(posedge ref_clk) begin
        if (reset || !ramp_busy) begin
            timer <= reload;
        end else if (tick_int) begin
            timer <= reload; // R22
        end else begin
            timer <= timer - TW'(1);
        end
    end
    assign step_strobe = ramp_busy && (cfg.ramp_ext_clk ? mod_rise : tick_int); // R21

    // ****************************************
    // Ramp sequencer
    // ****************************************
    rfw_state_t state;
    logic [`RFW_STEP_W-1:0] steps;
    rfw_n_t offset;
    rfw_n_t dstep;
    assign dstep = NW'({{(NW-`RFW_DEV_W){cfg.deviation_word[`RFW_DEV_W-1]}},
                       cfg.deviation_word} << cfg.deviation_shift); // R4 R1
    wire last = (steps + `RFW_STEP_W'(1) >= cfg.step_count); // R6
    always_ff @(posedge ref_clk) begin
        if (reset || !ramp_start) begin
            state <= RFW_IDLE;
            steps <= '0;
            offset <= '0; // R8
        end else begin
            case (state)
                RFW_IDLE: begin
                    state <= RFW_UP;
                    steps <= '0;
                    offset <= '0; // R8
                end
                RFW_UP: if (step_strobe) begin
                    offset <= offset + dstep; // R9
                    steps <= last ? '0 : steps + `RFW_STEP_W'(1);
                    if (last) begin
                        case (cfg.ramp_type)
                            `RFW_TYPE_TRI: state <= RFW_DOWN; // R12 R20
                            `RFW_TYPE_SRB: state <= RFW_HOLD; // R9 R20
                            default: state <= RFW_RESTORE; // R10 R11
                        endcase
                    end
                end
                RFW_DOWN: if (step_strobe) begin
                    offset <= offset - dstep; // R12
                    steps <= last ? '0 : steps + `RFW_STEP_W'(1);
                    if (last) begin
                        state <= RFW_UP;
                    end
                end
                RFW_RESTORE: if (step_strobe) begin
                    offset <= '0; // R10
                    state <= (cfg.ramp_type == `RFW_TYPE_SAW) ? RFW_UP : RFW_HOLD; // R11
                end
                RFW_HOLD: state <= RFW_HOLD;
                default: state <= RFW_IDLE;
            endcase
        end
    end
    assign ramp_busy = (state == RFW_UP) || (state == RFW_DOWN) || (state == RFW_RESTORE);

    // ****************************************
    // Output divide value and phase
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            n_out <= '0;
            phase_flip <= 1'b0;
        end else begin
            if (fsk_en && !ramp_start) begin
                n_out <= mod_level ? n_prog + dstep : n_prog - dstep; // R1 R2
            end else begin
                n_out <= n_prog + offset; // R8
            end
            phase_flip <= psk_en & mod_level; // R3
        end
    end

    // ****************************************
    // Slip reduction cells
    // ****************************************
    logic passed;
    always_ff @(posedge ref_clk) begin
        if (reset || !slip_reduction_en) begin
            extra_cells <= '0; // R18
            cell_source <= 1'b0;
            passed <= 1'b0;
        end else if (target_passed || passed) begin
            passed <= (extra_cells > `RFW_CELL_W'(1)); // R17
            if (extra_cells != '0) begin
                extra_cells <= extra_cells - `RFW_CELL_W'(1); // R17
            end
        end else if (slip_imminent && extra_cells < `RFW_CELL_W'(`RFW_CELLS)) begin
            extra_cells <= extra_cells + `RFW_CELL_W'(1); // R15 R16
            cell_source <= slip_up; // R15
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sr_gate_a: assert property (@(posedge ref_clk) disable iff (reset) // R18
        !slip_reduction_en |=> extra_cells == '0) else $error("cells on while disabled");
    // A plain bound check would hold by width; watch the counter at its top instead
    sr_max_a: assert property (@(posedge ref_clk) disable iff (reset) // R16
        slip_reduction_en && extra_cells == `RFW_CELL_W'(`RFW_CELLS) ##1 slip_reduction_en
        |-> extra_cells >= `RFW_CELL_W'(`RFW_CELLS - 1)) else $error("cell count wrapped");
    sr_add_a: assert property (@(posedge ref_clk) disable iff (reset) // R15 R16
        slip_reduction_en && slip_imminent && !target_passed && !passed
        && extra_cells < `RFW_CELL_W'(`RFW_CELLS) ##1 slip_reduction_en
        |-> extra_cells == $past(extra_cells) + `RFW_CELL_W'(1)) else $error("cell not added");
    sr_fall_a: assert property (@(posedge ref_clk) disable iff (reset) // R17
        slip_reduction_en && target_passed && extra_cells != '0 ##1 slip_reduction_en
        |-> extra_cells == $past(extra_cells) - `RFW_CELL_W'(1)) else $error("cell off");
    psk_phase_a: assert property (@(posedge ref_clk) disable iff (reset) // R3
        psk_en && mod_level |=> phase_flip) else $error("phase not flipped");
    fsk_dir_a: assert property (@(posedge ref_clk) disable iff (reset) // R2
        fsk_en && !ramp_start && !mod_level |=> n_out == $past(n_prog) - $past(dstep))
        else $error("fsk down wrong");
    ramp_step_a: assert property (@(posedge ref_clk) disable iff (reset) // R4
        ramp_start && state == RFW_UP && step_strobe ##1 ramp_start
        |-> offset == $past(offset) + $past(dstep)) else $error("step size wrong");
    saw_restore_a: assert property (@(posedge ref_clk) disable iff (reset) // R10
        ramp_start && state == RFW_RESTORE && step_strobe ##1 ramp_start |-> offset == '0)
        else $error("not restored");
    burst_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // R9
        state == RFW_HOLD && ramp_start |=> $stable(offset)) else $error("hold moved");
    timer_one_a: assert property (@(posedge ref_clk) disable iff (reset) // R22
        tick_int |=> !tick_int || reload <= TW'(1)) else $error("double strobe");
    start_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // R8
        !ramp_start |=> offset == '0) else $error("start not at base");
    ext_clk_a: assert property (@(posedge ref_clk) disable iff (reset) // R21
        ramp_busy && cfg.ramp_ext_clk && !mod_rise |-> !step_strobe) else $error("timer stepped");
    tri_cov: cover property (@(posedge ref_clk) state == RFW_DOWN ##1 state == RFW_UP);
    saw_cov: cover property (@(posedge ref_clk) state == RFW_RESTORE ##1 state == RFW_UP);
    cell_cov: cover property (@(posedge ref_clk) extra_cells == `RFW_CELL_W'(`RFW_CELLS));
    ext_cov: cover property (@(posedge ref_clk) cfg.ramp_ext_clk && step_strobe);
endmodule

// file: inc/rfw_cfg.svh
// Purpose: constants of the ramp and modulation engine
// Assumes: included by the package and the engine
// Notes: encodings, widths and limits only; no logic here
`ifndef RFW_CFG_SVH
`define RFW_CFG_SVH
`define RFW_INT_W 12
`define RFW_FRAC_W 25
`define RFW_DEV_W 16
`define RFW_SHIFT_W 4
`define RFW_DIV_W 12
`define RFW_STEP_W 20
`define RFW_CELLS 7
`define RFW_CELL_W 3
`define RFW_TYPE_SAW 2'h0
`define RFW_TYPE_TRI 2'h1
`define RFW_TYPE_SSB 2'h2
`define RFW_TYPE_SRB 2'h3
`define RFW_INT_SPAN 13'h0100
`endif

// file: inc/rfw_pkg.sv
// Purpose: types of the ramp and modulation engine
// Assumes: rfw_cfg.svh constants
// Notes: N value is integer and fraction joined
`include "rfw_cfg.svh"
package rfw_pkg;
    typedef logic [`RFW_INT_W+`RFW_FRAC_W-1:0] rfw_n_t;
    typedef struct packed {
        logic [`RFW_DEV_W-1:0] deviation_word;
        logic [`RFW_SHIFT_W-1:0] deviation_shift;
        logic [`RFW_DIV_W-1:0] clk1_div;
        logic [`RFW_DIV_W-1:0] clk2_div;
        logic [`RFW_STEP_W-1:0] step_count;
        logic [1:0] ramp_type;
        logic ramp_ext_clk;
    } rfw_ramp_cfg_t;
    typedef enum logic [2:0] {RFW_IDLE, RFW_UP, RFW_DOWN, RFW_RESTORE, RFW_HOLD} rfw_state_t;
endpackage

// file: testbench/rfw_host.sv
// Purpose: host model that programs the ramp engine's settings
// Assumes: settings are static while a ramp runs
// Notes: applies the settings, then the divide value, then ramp start
`timescale 1ns/1ns
module rfw_host
    import rfw_pkg::*;
(
    input wire logic ref_clk, // Phase-detector clock
    output rfw_pkg::rfw_ramp_cfg_t cfg, // Ramp settings
    output rfw_pkg::rfw_n_t n_prog, // Programmed divide value
    output logic ramp_start // Ramp enable
);
    import rfw_pkg::*;
    initial begin
        cfg = '0;
        n_prog = '0;
        ramp_start = 1'b0;
    end
    task automatic start(input rfw_ramp_cfg_t c, input rfw_n_t n);
        if (c.step_count > 20'h00010) c.step_count = 20'h00010;
        @(posedge ref_clk);
        cfg <= c;
        @(posedge ref_clk);
        n_prog <= n;
        @(posedge ref_clk);
        ramp_start <= 1'b1;
    endtask
    task automatic stop;
        @(posedge ref_clk);
        ramp_start <= 1'b0;
    endtask
endmodule

// file: testbench/tb.sv
// Purpose: self-checking bench of the ramp, keying and slip logic
// Assumes: slip reduction used with positive detector polarity only
// Notes: small random dividers keep the run short
`timescale 1ns/1ns
`include "rfw_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb;
    import rfw_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, fsk_en = 1'b0, psk_en = 1'b0, mod_pin = 1'b0;
    logic slip_reduction_en = 1'b0, slip_imminent = 1'b0, slip_up = 1'b0, target_passed = 1'b0;
    logic ramp_start, phase_flip, cell_source, ramp_busy, step_strobe;
    logic [2:0] extra_cells;
    rfw_ramp_cfg_t cfg;
    rfw_n_t n_prog, n_out, n_hi, d2;
    int n_fail = 0, num_checks = 0, seed = 32'h8939da87;
    always #25 ref_clk = ~ref_clk;
    rfw_host rfw_host_i(.ref_clk(ref_clk), .cfg(cfg), .n_prog(n_prog), .ramp_start(ramp_start));
    rfw_engine rfw_engine_i(.ref_clk(ref_clk), .reset(reset), .n_prog(n_prog), .cfg(cfg),
        .ramp_start(ramp_start), .fsk_en(fsk_en), .psk_en(psk_en), .mod_pin(mod_pin),
        .slip_reduction_en(slip_reduction_en), .slip_imminent(slip_imminent),
        .slip_up(slip_up), .target_passed(target_passed), .n_out(n_out),
        .phase_flip(phase_flip), .extra_cells(extra_cells), .cell_source(cell_source),
        .ramp_busy(ramp_busy), .step_strobe(step_strobe));
    function automatic rfw_n_t expect_n(rfw_n_t n, rfw_ramp_cfg_t c, int k);
        rfw_n_t d;
        d = rfw_n_t'($signed(c.deviation_word)) << c.deviation_shift;
        return n + d * rfw_n_t'(k);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic ramp(input logic [1:0] ty);
        rfw_ramp_cfg_t c;
        rfw_n_t n0;
        int sc, nstr, k, gap, got, t, per;
        c = '0;
        c.clk1_div = 12'h002 + 12'($random(seed) & 3);
        c.clk2_div = 12'h002 + 12'($random(seed) & 3);
        sc = 1 + ($random(seed) & 3);
        c.step_count = 20'(sc);
        c.ramp_type = ty;
        c.deviation_shift = 4'($random(seed) & 3);
        c.deviation_word = 16'h0010 + 16'($random(seed) & 16'h00ff);
        n0 = {12'h040, 25'($random(seed))};
        per = int'(c.clk1_div) * int'(c.clk2_div);
        case (ty)
            `RFW_TYPE_SRB: begin nstr = sc; k = sc; end
            `RFW_TYPE_SSB: begin nstr = sc + 1; k = 0; end
            `RFW_TYPE_SAW: begin nstr = sc + 2; k = 1; end
            default: begin nstr = sc + 1; k = sc - 1; end
        endcase
        rfw_host_i.start(c, n0);
        gap = 0; got = 0; t = 0;
        while (got < nstr && t < 2000) begin
            @(negedge ref_clk);
            t++;
            gap++;
            if (step_strobe === 1'b1) begin
                got++;
                if (got > 1) `CHK(gap, per)
                gap = 0;
            end
        end
        if (got < nstr) begin
            $display("FAIL t=%0t strobe timeout", $time);
            n_fail++;
            give_verdict;
        end
        tick(3);
        `CHK(n_out, expect_n(n0, c, k))
        `CHK(ramp_busy, ~ty[1])
        if (ty[1]) begin
            tick(3 * per);
            `CHK(n_out, expect_n(n0, c, k))
        end
        rfw_host_i.stop;
        tick(3);
        `CHK(n_out, n0)
        `CHK(ramp_busy, 1'b0)
    endtask
    // Steps come only from pin edges; the fast internal timer must not move the ramp
    task automatic ext_ramp;
        rfw_ramp_cfg_t c;
        rfw_n_t n0;
        c = '0;
        c.clk1_div = 12'h002;
        c.clk2_div = 12'h002;
        c.step_count = 20'h00003;
        c.ramp_type = `RFW_TYPE_SRB;
        c.ramp_ext_clk = 1'b1;
        c.deviation_word = 16'h0010 + 16'($random(seed) & 16'h00ff);
        n0 = {12'h080, 25'($random(seed))};
        rfw_host_i.start(c, n0);
        tick(20);
        `CHK(n_out, n0)
        repeat (4) begin
            mod_pin <= 1'b1;
            tick(6);
            mod_pin <= 1'b0;
            tick(6);
        end
        `CHK(n_out, expect_n(n0, c, 3))
        rfw_host_i.stop;
        tick(3);
        `CHK(n_out, n0)
    endtask
    task automatic pulse_slip(input int n);
        repeat (n) begin
            @(posedge ref_clk) slip_imminent <= 1'b1;
            @(posedge ref_clk) slip_imminent <= 1'b0;
        end
        tick(2);
    endtask
    initial begin
        tick(2);
        reset <= 1'b0;
        tick(1);
        `CHK(n_out, rfw_n_t'(0))
        repeat (2) for (int i = 0; i < 4; i++) ramp(2'(i));
        ext_ramp;
        fsk_en <= 1'b1;
        mod_pin <= 1'b1;
        tick(6);
        n_hi = n_out;
        mod_pin <= 1'b0;
        tick(6);
        d2 = expect_n('0, cfg, 2);
        `CHK(n_hi + n_out, n_prog + n_prog)
        `CHK((n_hi - n_out === d2) || (n_out - n_hi === d2), 1'b1)
        fsk_en <= 1'b0;
        psk_en <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            mod_pin <= 1'(i);
            tick(6);
            `CHK(phase_flip, 1'(i))
        end
        pulse_slip(2);
        `CHK(extra_cells, 3'h0)
        slip_reduction_en <= 1'b1;
        slip_up <= 1'($random(seed));
        pulse_slip(1);
        `CHK(extra_cells, 3'h1)
        `CHK(cell_source, slip_up)
        pulse_slip(8);
        `CHK(extra_cells, 3'h7)
        @(posedge ref_clk) target_passed <= 1'b1;
        @(posedge ref_clk) target_passed <= 1'b0;
        tick(20);
        `CHK(extra_cells, 3'h0)
        give_verdict;
    end
endmodule
